//--- hdl/ucsd_decoder.sv
// alpha field byte-to-character decoder with its output fifo
`timescale 1ns/100ps

// synchronous fifo, parameterised width and depth
module ucsd_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   output logic      [WIDTH-1:0] rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } ucsd_fptr_t;

   ucsd_fptr_t       ptr_q;
   ucsd_fptr_t       ptr_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic             do_wr;
   logic             do_rd;

   // full when pointers differ only in the wrap bit
   assign wr_ready_out = !((ptr_q.wp[AW] != ptr_q.rp[AW]) &&
                           (ptr_q.wp[AW-1:0] == ptr_q.rp[AW-1:0]));
   assign rd_valid_out = (ptr_q.wp != ptr_q.rp);
   assign rd_data_out  = mem_q[ptr_q.rp[AW-1:0]];
   assign do_wr        = wr_valid_in && wr_ready_out;
   assign do_rd        = rd_valid_out && rd_ready_in;

   // pointer advance
   always_comb begin
      ptr_d = ptr_q;
      if (do_wr) begin
         ptr_d.wp = ptr_q.wp + 1'b1;
      end
      if (do_rd) begin
         ptr_d.rp = ptr_q.rp + 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ptr_q <= '0;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   // storage, no reset needed
   always_ff @(posedge clk_in) begin
      if (do_wr) begin
         mem_q[ptr_q.wp[AW-1:0]] <= wr_data_in;
      end
   end
endmodule

// top: byte stream in, character stream out
module ucsd_decoder (
   input  wire logic        clk_in,
   input  wire logic        sys_rst_in,
   input  wire logic [7:0]  byte_in,
   input  wire logic        byte_valid_in,
   input  wire logic        byte_last_in,
   output logic             byte_ready_out,
   output logic      [15:0] char_out,
   output logic             char_wide_out,
   output logic             char_valid_out,
   input  wire logic        char_ready_in
);
   localparam ucsd_pkg::ucsd_dec_t DEC_RST = '{
      st:   ucsd_pkg::ST_HDR,
      form: ucsd_pkg::FM_PLAIN,
      cnt:  ucsd_pkg::CNT_RST,
      base: ucsd_pkg::BASE_RST,
      msb:  ucsd_pkg::MSB_RST
   };

   ucsd_pkg::ucsd_dec_t          cur_q;
   ucsd_pkg::ucsd_dec_t          cur_d;
   logic                         fifo_ready;
   logic                         acc;
   logic                         push_valid;
   logic [ucsd_pkg::CHAR_W-1:0]  push_data;
   logic [ucsd_pkg::CHAR_W-1:0]  rd_data;
   logic [15:0]                  pair;

   // a byte is taken only when the fifo can take its character
   assign byte_ready_out = fifo_ready;
   assign acc            = byte_valid_in && fifo_ready;
   assign pair           = {cur_q.msb, byte_in};
   assign char_out       = rd_data[15:0];
   assign char_wide_out  = rd_data[16];

   // decode state machine
   always_comb begin
      cur_d      = cur_q;
      push_valid = 1'b0;
      push_data  = '0;
      if (acc) begin
         unique case (cur_q.st)
            ucsd_pkg::ST_HDR: begin
               // form chosen once from the header byte
               if (byte_in == ucsd_pkg::HDR_PAIR) begin
                  cur_d.form = ucsd_pkg::FM_PAIR;
                  cur_d.st   = ucsd_pkg::ST_PAIR_HI;
               end else if (byte_in == ucsd_pkg::HDR_HALF) begin
                  cur_d.form = ucsd_pkg::FM_HALF;
                  cur_d.st   = ucsd_pkg::ST_CNT;
               end else if (byte_in == ucsd_pkg::HDR_FULL) begin
                  cur_d.form = ucsd_pkg::FM_FULL;
                  cur_d.st   = ucsd_pkg::ST_CNT;
               end else begin
                  cur_d.form = ucsd_pkg::FM_PLAIN;
                  cur_d.st   = ucsd_pkg::ST_PLAIN;
                  push_valid = !byte_in[ucsd_pkg::TOP_BIT];
                  push_data  = ucsd_pkg::ucsd_char(byte_in, cur_q.base);
               end
            end
            ucsd_pkg::ST_PLAIN: begin
               // default alphabet; top-bit bytes are fill
               push_valid = !byte_in[ucsd_pkg::TOP_BIT];
               push_data  = ucsd_pkg::ucsd_char(byte_in, cur_q.base);
            end
            ucsd_pkg::ST_PAIR_HI: begin
               // held until partner arrives; dropped if field ends
               cur_d.msb = byte_in;
               cur_d.st  = ucsd_pkg::ST_PAIR_LO;
            end
            ucsd_pkg::ST_PAIR_LO: begin
               // lower byte number is the high half
               push_valid = !((cur_q.msb == ucsd_pkg::PAD_BYTE) &&
                              (byte_in == ucsd_pkg::PAD_BYTE));
               push_data  = {1'b1, pair};
               cur_d.st   = ucsd_pkg::ST_PAIR_HI;
            end
            ucsd_pkg::ST_CNT: begin
               cur_d.cnt = byte_in;
               cur_d.st  = ucsd_pkg::ST_PTR_HI;
            end
            ucsd_pkg::ST_PTR_HI: begin
               if (cur_q.form == ucsd_pkg::FM_HALF) begin
                  // half page: bit 15 and bits 6:0 zero
                  cur_d.base = {1'b0, byte_in, 7'h00};
                  cur_d.st   = ucsd_pkg::ST_CHARS;
               end else begin
                  cur_d.base = {byte_in, 8'h00};
                  cur_d.st   = ucsd_pkg::ST_PTR_LO;
               end
            end
            ucsd_pkg::ST_PTR_LO: begin
               cur_d.base = {cur_q.base[15:8], byte_in};
               cur_d.st   = ucsd_pkg::ST_CHARS;
            end
            ucsd_pkg::ST_CHARS: begin
               // per-byte choice of default or offset
               if (cur_q.cnt != 8'h00) begin
                  push_valid = 1'b1;
                  push_data  = ucsd_pkg::ucsd_char(byte_in, cur_q.base);
                  cur_d.cnt  = cur_q.cnt - 8'h01;
               end
               // count exhausted: rest of field ignored
            end
         endcase
         // end of field: next byte is a new header
         if (byte_last_in) begin
            cur_d.st = ucsd_pkg::ST_HDR;
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cur_q <= DEC_RST;
      end else begin
         cur_q <= cur_d;
      end
   end

   // character buffer with back-pressure to the byte source
   ucsd_fifo #(
      .WIDTH (ucsd_pkg::CHAR_W),
      .DEPTH (ucsd_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk_in       (clk_in),
      .sys_rst_in   (sys_rst_in),
      .wr_data_in   (push_data),
      .wr_valid_in  (push_valid),
      .wr_ready_out (fifo_ready),
      .rd_data_out  (rd_data),
      .rd_valid_out (char_valid_out),
      .rd_ready_in  (char_ready_in)
   );

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   sequence s_hdr_wide;
      (cur_q.st == ucsd_pkg::ST_HDR) && acc && !byte_last_in &&
      ((byte_in == ucsd_pkg::HDR_HALF) || (byte_in == ucsd_pkg::HDR_FULL));
   endsequence

   sequence s_cnt_taken;
      (cur_q.st == ucsd_pkg::ST_CNT) && acc && !byte_last_in;
   endsequence

   AST_PAIR_ORDER: assert property (
      (cur_q.st == ucsd_pkg::ST_PAIR_LO) && acc && (pair != 16'hFFFF)
      |-> push_valid && (push_data == {1'b1, cur_q.msb, byte_in}))
      else $error("pair form character not high byte first");

   AST_PAIR_PAD: assert property (
      (cur_q.st == ucsd_pkg::ST_PAIR_LO) && acc && (pair == 16'hFFFF)
      |-> !push_valid)
      else $error("padding pair was output");

   AST_ODD_BYTE: assert property (
      (cur_q.st == ucsd_pkg::ST_PAIR_HI) && acc && byte_last_in
      |-> !push_valid ##1 (cur_q.st == ucsd_pkg::ST_HDR))
      else $error("dangling pair byte not ignored");

   AST_COUNT_LOAD: assert property (
      s_hdr_wide ##1 s_cnt_taken
      |=> (cur_q.cnt == $past(byte_in)) && (cur_q.st == ucsd_pkg::ST_PTR_HI))
      else $error("character count not taken from second byte");

   AST_HALF_BASE: assert property (
      (cur_q.st == ucsd_pkg::ST_PTR_HI) && (cur_q.form == ucsd_pkg::FM_HALF)
      && acc && !byte_last_in
      |=> (cur_q.base[14:7] == $past(byte_in)) && !cur_q.base[15] &&
          (cur_q.base[6:0] == 7'h00) && (cur_q.st == ucsd_pkg::ST_CHARS))
      else $error("half page pointer wrongly formed");

   AST_SEPTET: assert property (
      (cur_q.st == ucsd_pkg::ST_CHARS) && acc && (cur_q.cnt != 8'h00) &&
      !byte_in[7]
      |-> push_valid && (push_data == {10'h000, byte_in[6:0]}))
      else $error("default character wrongly output");

   AST_OFFSET: assert property (
      (cur_q.st == ucsd_pkg::ST_CHARS) && acc && (cur_q.cnt != 8'h00) &&
      byte_in[7]
      |-> push_valid && push_data[16] &&
          (push_data[15:0] == cur_q.base + {9'h000, byte_in[6:0]}))
      else $error("offset character wrongly output");

   AST_FULL_BASE: assert property (
      (cur_q.st == ucsd_pkg::ST_PTR_LO) && acc && !byte_last_in
      |=> (cur_q.base[7:0] == $past(byte_in)) && $stable(cur_q.base[15:8]) &&
          (cur_q.st == ucsd_pkg::ST_CHARS))
      else $error("full pointer not assembled from third and fourth bytes");

   AST_FORM_HOLD: assert property (
      (cur_q.st != ucsd_pkg::ST_HDR) |=> $stable(cur_q.form))
      else $error("coding form changed inside a record");

   AST_COUNT_STOP: assert property (
      (cur_q.st == ucsd_pkg::ST_CHARS) && (cur_q.cnt == 8'h00) |-> !push_valid)
      else $error("character emitted past the count");

   AST_COUNT_DOWN: assert property (
      (cur_q.st == ucsd_pkg::ST_CHARS) && acc && (cur_q.cnt != 8'h00) &&
      !byte_last_in
      |=> cur_q.cnt == $past(cur_q.cnt) - 8'h01)
      else $error("count not decremented per character");
endmodule

//--- hdl/ucsd_pkg.sv
// constants, types and helpers for the alpha field character decoder
package ucsd_pkg;
   // header bytes selecting the coding form, and the pair padding byte
   localparam logic [7:0] HDR_PAIR     = 8'h80;
   localparam logic [7:0] HDR_HALF     = 8'h81;
   localparam logic [7:0] HDR_FULL     = 8'h82;
   localparam logic [7:0] PAD_BYTE     = 8'hFF;
   // field positions
   localparam int         TOP_BIT      = 7;
   localparam int         HALF_LSB     = 7;
   // buffer shape: wide flag plus 16-bit code point
   localparam int         CHAR_W       = 17;
   localparam int         FIFO_DEPTH   = 16;
   // reset values
   localparam logic [7:0]  CNT_RST     = 8'h00;
   localparam logic [15:0] BASE_RST    = 16'h0000;
   localparam logic [7:0]  MSB_RST     = 8'h00;

   typedef enum logic [2:0] {
      ST_HDR,
      ST_CNT,
      ST_PTR_HI,
      ST_PTR_LO,
      ST_PAIR_HI,
      ST_PAIR_LO,
      ST_CHARS,
      ST_PLAIN
   } ucsd_state_t;

   typedef enum logic [1:0] {
      FM_PLAIN,
      FM_PAIR,
      FM_HALF,
      FM_FULL
   } ucsd_form_t;

   typedef struct packed {
      ucsd_state_t st;
      ucsd_form_t  form;
      logic [7:0]  cnt;
      logic [15:0] base;
      logic [7:0]  msb;
   } ucsd_dec_t;

   // top bit clear: 7-bit default character; set: offset onto base pointer
   function automatic logic [CHAR_W-1:0] ucsd_char(input logic [7:0]  b,
                                                   input logic [15:0] base);
      logic [15:0] sum;
      sum = base + {9'h000, b[6:0]};
      if (b[TOP_BIT]) begin
         return {1'b1, sum};
      end
      return {1'b0, 9'h000, b[6:0]};
   endfunction
endpackage

//--- verification/ucsd_decoder_bench.sv
// self-checking testbench for the alpha field character decoder
`timescale 1ns/100ps
module ucsd_decoder_bench;
   logic        clk_in     = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic [7:0]  byte_in;
   logic        byte_valid_in;
   logic        byte_last_in;
   logic        byte_ready_out;
   logic [15:0] char_out;
   logic        char_wide_out;
   logic        char_valid_out;
   logic        char_ready_in = 1'b0;
   logic        hold          = 1'b0;
   logic        rdy;
   logic [16:0] e;
   logic [16:0] exp_q[$];
   logic [7:0]  r[$];
   int          err_count     = 0;
   int          compares      = 0;
   int          j;
   int          n;
   int          h;

   ucsd_decoder dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .byte_in(byte_in),
      .byte_valid_in(byte_valid_in), .byte_last_in(byte_last_in),
      .byte_ready_out(byte_ready_out), .char_out(char_out), .char_wide_out(char_wide_out),
      .char_valid_out(char_valid_out), .char_ready_in(char_ready_in));
   ucsd_reader_model rdr (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .byte_ready_in(byte_ready_out), .byte_out(byte_in), .byte_valid_out(byte_valid_in),
      .byte_last_out(byte_last_in));

   always #2.5 clk_in = ~clk_in;

   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // reference decoding of one record, then hand it to the reader
   task automatic send(input logic [7:0] b[$]);
      int          m;
      int          i;
      int          k;
      logic [15:0] base;
      m    = b.size();
      k    = 0;
      base = 16'h0000;
      if (b[0] == ucsd_pkg::HDR_PAIR) begin
         for (i = 1; i + 1 < m; i += 2) begin
            if ({b[i], b[i+1]} != 16'hFFFF) exp_q.push_back({1'b1, b[i], b[i+1]});
         end
      end else if (b[0] == ucsd_pkg::HDR_HALF || b[0] == ucsd_pkg::HDR_FULL) begin
         i = (b[0] == ucsd_pkg::HDR_HALF) ? 3 : 4;
         if (m > i) base = (i == 3) ? {1'b0, b[2], 7'h00} : {b[2], b[3]};
         while (i < m && k < b[1]) begin
            exp_q.push_back(b[i][7] ? {1'b1, 16'(base + {9'h000, b[i][6:0]})}
                                    : {10'h000, b[i][6:0]});
            i++;
            k++;
         end
      end else begin
         for (i = 0; i < m; i++) if (!b[i][7]) exp_q.push_back({10'h000, b[i][6:0]});
      end
      for (i = 0; i < m; i++) rdr.q.push_back({i == m - 1, b[i]});
   endtask

   // wait for the stream to settle, then expect an empty output
   task automatic drain(input string name);
      int t;
      for (t = 0; t < 3000 && (exp_q.size() != 0 || rdr.q.size() != 0); t++) @(negedge clk_in);
      repeat (3) @(negedge clk_in);
      check("chars left", 17'(exp_q.size()), 17'h0);
      check("output idle", {16'h0000, char_valid_out}, 17'h0);
      $display("test %s done", name);
   endtask

   // consumer: random ready, each taken char compared with the model
   always @(negedge clk_in) begin
      rdy = !hold && $urandom_range(3) != 0;
      char_ready_in <= rdy;
      if (rdy && char_valid_out === 1'b1) begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 17'hX;
         check("char", {char_wide_out, char_out}, e);
      end
   end

   initial begin
      #(60000 * 5);
      err_count++;
      final_report();
   end

   initial begin
      void'($urandom(32'hFBDD));
      repeat (20) @(negedge clk_in);
      sys_rst_in = 1'b0;
      send({8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h41, 8'hFF, 8'hFF});
      send({8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31});
      send({8'h80, 8'h00, 8'h41, 8'h04, 8'h10, 8'hFF, 8'hFF, 8'hFF});
      send({8'h41, 8'hC2, 8'h30});
      send({8'h81, 8'h00, 8'h13, 8'h95});
      send({8'h82});
      send({8'h82, 8'h03, 8'h05});
      send({8'h80, 8'hFF, 8'h41});
      send({8'h81, 8'h02, 8'hFF, 8'hFF, 8'h80, 8'h82});
      send({8'hC5, 8'h41, 8'h30});
      drain("directed forms");
      // stall the consumer until the buffer refuses bytes
      hold = 1'b1;
      r    = {8'h80};
      for (j = 0; j < 40; j++) r.push_back(8'(j + 1));
      send(r);
      for (j = 0; j < 200 && byte_ready_out !== 1'b0; j++) @(negedge clk_in);
      repeat (4) @(negedge clk_in);
      check("bytes unsent", 17'(rdr.q.size()), 17'h00008);
      check("ready low", {16'h0000, byte_ready_out}, 17'h0);
      hold = 1'b0;
      drain("buffer full");
      // random records with reader gaps
      rdr.slow = 1'b1;
      for (j = 0; j < 40; j++) begin
         h = $urandom_range(3);
         n = $urandom_range(12, 1);
         r = {};
         r.push_back(h == 0 ? ucsd_pkg::HDR_PAIR : h == 1 ? ucsd_pkg::HDR_HALF :
                     h == 2 ? ucsd_pkg::HDR_FULL : 8'($urandom_range(127)));
         while (r.size() < n) r.push_back($urandom_range(5) == 0 ? 8'hFF : 8'($urandom));
         if ((h == 1 || h == 2) && r.size() > 1) r[1] = 8'($urandom_range(10));
         send(r);
      end
      drain("random records");
      final_report();
   end
endmodule

//--- verification/ucsd_reader_model.sv
// record reader model feeding alpha field bytes to the decoder
`timescale 1ns/100ps
module ucsd_reader_model (
   input  wire logic       clk_in,
   input  wire logic       sys_rst_in,
   input  wire logic       byte_ready_in,
   output logic      [7:0] byte_out,
   output logic            byte_valid_out,
   output logic            byte_last_out
);
   logic [8:0] q[$];          // bit 8 marks the closing byte of a record
   logic       took  = 1'b0;
   logic       slow  = 1'b0;  // inserts random idle gaps between bytes
   initial begin
      byte_out       = 8'h00;
      byte_valid_out = 1'b0;
      byte_last_out  = 1'b0;
   end
   // note a byte taken at the rising edge
   always @(posedge clk_in) begin
      took = byte_valid_out && byte_ready_in && !sys_rst_in;
   end
   // offer the next byte, held until taken; released lines toggle
   always @(negedge clk_in) begin
      if (took) begin
         void'(q.pop_front());
      end
      if ((took || !byte_valid_out) && q.size() != 0 && (!slow || $urandom_range(3) != 0)) begin
         byte_out       <= q[0][7:0];
         byte_valid_out <= 1'b1;
         byte_last_out  <= q[0][8];
      end else if (took || !byte_valid_out) begin
         byte_out       <= ~byte_out;
         byte_valid_out <= 1'b0;
         byte_last_out  <= ~byte_last_out;
      end
      took = 1'b0;
   end
endmodule
